/* File: soh_defs.svh */
// Register offsets, field positions, reset values and timing counts for the section overhead bank
`ifndef SOH_DEFS_SVH
`define SOH_DEFS_SVH

// Register offsets
`define SOH_ADDR_TX_SYNC 8'h0F
`define SOH_ADDR_RX_CTRL 8'h10
`define SOH_ADDR_RX_STATUS 8'h11
`define SOH_ADDR_CNT_LOW 8'h12
`define SOH_ADDR_CNT_HIGH 8'h13
`define SOH_ADDR_TX_CTRL 8'h14
`define SOH_ADDR_TX_DIAG 8'h15

// Receive control fields
`define SOH_RXC_PER_FRAME 7
`define SOH_RXC_DESCR_OFF 6
`define SOH_RXC_FORCE_REFRAME 5
`define SOH_RXC_REDUCED_SEARCH 4
`define SOH_RXC_PARITY_EN 3
`define SOH_RXC_LOS_EN 2
`define SOH_RXC_LOF_EN 1
`define SOH_RXC_OOF_EN 0

// Receive status fields
`define SOH_RXS_PARITY_FLAG 6
`define SOH_RXS_LOS_FLAG 5
`define SOH_RXS_LOF_FLAG 4
`define SOH_RXS_OOF_FLAG 3

// Transmit control and diagnostic fields
`define SOH_TXC_SCRAMBLER_OFF 6
`define SOH_TXC_LINE_AIS 0
`define SOH_TXD_ZERO_STREAM 2
`define SOH_TXD_PARITY_INVERT 1
`define SOH_TXD_FRAMING_INJECT 0

// Reset values and masks
`define SOH_RST_TX_SYNC 8'h00
`define SOH_RST_RX_CTRL 8'h00
`define SOH_RST_TX_CTRL 8'h00
`define SOH_RST_TX_DIAG 8'h00
`define SOH_RXC_STORE_MASK 8'hDF
`define SOH_TXC_STORE_MASK 8'h7F
`define SOH_TXD_STORE_MASK 8'h07
`define SOH_A1_MSB_FLIP 8'h80
`define SOH_ALL_ONES 8'hFF

// Timing: poll transfer bound
`define SOH_CLK_PERIOD_NS 50
`define SOH_POLL_TIME_NS 7000
`define SOH_POLL_MAX_CYCLES (`SOH_POLL_TIME_NS / `SOH_CLK_PERIOD_NS)

`endif

/* File: soh_pkg.sv */
// Types shared by the section overhead register bank
package soh_pkg;

    // Force-reframe request sequencing
    typedef enum logic [2:0] {
        SOH_RF_IDLE = 3'b001,
        SOH_RF_PENDING = 3'b010,
        SOH_RF_FIRE = 3'b100
    } soh_reframe_t;

    // Kind of the transmit byte in the current slot
    typedef enum logic [2:0] {
        SOH_KIND_PAYLOAD = 3'h0,
        SOH_KIND_SECTION_OH = 3'h1,
        SOH_KIND_A1 = 3'h2,
        SOH_KIND_B1 = 3'h3,
        SOH_KIND_Z1_FIRST = 3'h4
    } soh_kind_t;

    // Whole state of the bank
    typedef struct packed {
        logic [7:0] tx_sync;
        logic [7:0] rx_ctrl;
        logic [7:0] tx_ctrl;
        logic [7:0] tx_diag;
        logic [3:0] flags;
        logic [2:0] prev_alarm;
        logic [15:0] acc;
        logic [15:0] count;
        logic [7:0] rdata;
        logic ais_on;
        soh_reframe_t reframe;
        logic [7:0] serial_sr;
        logic [7:0] tx_out;
    } soh_state_t;

endpackage : soh_pkg

/* File: soh_section_regs.sv */
// Section overhead control, status, parity counting and transmit overhead shaping
// Functional notes
// - Programmed sync byte goes in first Z1 slot, bit 7 sent first.
// - Serially inserted Z1 byte overrides the programmed sync byte.
// - Alarm state changes raise interrupt when that alarm's enable is set.
// - Parity error raises interrupt when parity interrupt enable is set.
// - Reduced search uses first A1 and four bits of first A2.
// - Full search examines every A1 and A2 byte.
// - Force reframe drives receiver out of frame at next frame boundary.
// - Descrambler-off bit bypasses receive descrambling.
// - Per-frame mode adds one count per errored B1, else every bit.
// - Alarm state bits show live receive alarm status.
// - Alarm flags set on any state change, clear on status read.
// - Parity flag set on any B1 error, clears on status read.
// - Sixteen-bit error count readable as low and high bytes.
// - Write to count address latches count and restarts accumulation, losing nothing.
// - Meter-load write also latches the section error count.
// - Line AIS insertion starts and stops on frame boundaries.
// - During line AIS all non-section-overhead bits are forced to one.
// - Line AIS request is register bit OR external alarm pin.
// - Scrambler-off bit bypasses transmit scrambling.
// - Framing inject sends A1 with MSB flipped, 0x76 for 0xF6.
// - Parity invert sends the B1 byte inverted.
// - Zero-stream force drives the whole transmit stream to zero.
`include "soh_defs.svh"

module soh_section_regs
    import soh_pkg::*;
#(
    parameter int CNT_W = 16
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    output logic [7:0] rd_data,
    // Meter load from the master reset register
    input wire logic meter_load,
    // Receive section processor status
    input wire logic rx_frame_start,
    input wire logic misframe_state,
    input wire logic frame_loss_state,
    input wire logic signal_loss_state,
    input wire logic b1_check,
    input wire logic [3:0] b1_err_bits,
    // Receive section processor controls
    output logic reduced_frame_search,
    output logic descrambler_off,
    output logic force_reframe,
    // Transmit section processor stream
    input wire logic tx_frame_start,
    input wire logic [2:0] tx_byte_kind,
    input wire logic [7:0] tx_byte_in,
    input wire logic ext_line_alarm_pin,
    input wire logic overhead_insert_enable_pin,
    input wire logic overhead_insert_serial_in,
    output logic [7:0] tx_byte_out,
    output logic scrambler_off,
    output logic line_alarm_active,
    // Interrupt
    output logic irq
);

    soh_state_t s;
    soh_state_t next_s;

    logic wr_rx_ctrl;
    logic rd_status;
    logic poll;
    logic [2:0] alarm_now;
    logic [3:0] events;
    logic [3:0] enables;
    logic [15:0] inc;
    logic [16:0] sum;
    logic [7:0] status_view;
    soh_kind_t kind;

    // Decode and event gathering
    always_comb
    begin
        kind = soh_kind_t'(tx_byte_kind);
        wr_rx_ctrl = wr_strobe && (addr == `SOH_ADDR_RX_CTRL);
        rd_status = rd_strobe && (addr == `SOH_ADDR_RX_STATUS);
        poll = meter_load || (wr_strobe && ((addr == `SOH_ADDR_CNT_LOW) || (addr == `SOH_ADDR_CNT_HIGH)));
        alarm_now = {signal_loss_state, frame_loss_state, misframe_state};
        events = {b1_check && (b1_err_bits != 4'h0), alarm_now ^ s.prev_alarm};
        enables = {s.rx_ctrl[`SOH_RXC_PARITY_EN], s.rx_ctrl[`SOH_RXC_LOS_EN],
                   s.rx_ctrl[`SOH_RXC_LOF_EN], s.rx_ctrl[`SOH_RXC_OOF_EN]};
        // One per errored B1 or every errored bit
        if (!b1_check)
        begin
            inc = 16'h0000;
        end
        else if (s.rx_ctrl[`SOH_RXC_PER_FRAME])
        begin
            inc = {15'h0000, b1_err_bits != 4'h0};
        end
        else
        begin
            inc = {12'h000, b1_err_bits};
        end
        sum = {1'b0, s.acc} + {1'b0, inc};
        status_view = {1'b0, s.flags, alarm_now};
    end

    // Next-state logic
    always_comb
    begin
        next_s = s;
        next_s.rdata = 8'h00;
        // Register writes
        if (wr_strobe)
        begin
            case (addr)
                `SOH_ADDR_TX_SYNC: next_s.tx_sync = wr_data;
                `SOH_ADDR_RX_CTRL: next_s.rx_ctrl = wr_data & `SOH_RXC_STORE_MASK;
                `SOH_ADDR_TX_CTRL: next_s.tx_ctrl = wr_data & `SOH_TXC_STORE_MASK;
                `SOH_ADDR_TX_DIAG: next_s.tx_diag = wr_data & `SOH_TXD_STORE_MASK;
                default: next_s.tx_sync = s.tx_sync;
            endcase
        end
        // Register reads, data in the following cycle
        if (rd_strobe)
        begin
            case (addr)
                `SOH_ADDR_TX_SYNC: next_s.rdata = s.tx_sync;
                `SOH_ADDR_RX_CTRL: next_s.rdata = s.rx_ctrl;
                `SOH_ADDR_RX_STATUS: next_s.rdata = status_view;
                `SOH_ADDR_CNT_LOW: next_s.rdata = s.count[7:0];
                `SOH_ADDR_CNT_HIGH: next_s.rdata = s.count[15:8];
                `SOH_ADDR_TX_CTRL: next_s.rdata = s.tx_ctrl;
                `SOH_ADDR_TX_DIAG: next_s.rdata = s.tx_diag;
                default: next_s.rdata = 8'h00;
            endcase
        end
        // Sticky flags: a new event wins over the read clear
        next_s.flags = (rd_status ? 4'h0 : s.flags) | events;
        next_s.prev_alarm = alarm_now;
        // Error accumulation with coincident events carried into the new cycle
        if (poll)
        begin
            next_s.count = s.acc;
            next_s.acc = inc;
        end
        else
        begin
            next_s.acc = sum[16] ? 16'hFFFF : sum[15:0];
        end
        // Force-reframe sequencing
        case (s.reframe)
            SOH_RF_IDLE:
            begin
                if (wr_rx_ctrl && wr_data[`SOH_RXC_FORCE_REFRAME])
                begin
                    next_s.reframe = SOH_RF_PENDING;
                end
            end
            SOH_RF_PENDING:
            begin
                if (rx_frame_start)
                begin
                    next_s.reframe = SOH_RF_FIRE;
                end
            end
            SOH_RF_FIRE:
            begin
                next_s.reframe = SOH_RF_IDLE;
            end
            default:
            begin
                next_s.reframe = SOH_RF_IDLE;
            end
        endcase
        // Line AIS follows its request only at frame boundaries
        if (tx_frame_start)
        begin
            next_s.ais_on = s.tx_ctrl[`SOH_TXC_LINE_AIS] | ext_line_alarm_pin;
        end
        // Serial overhead byte, first bit into the top
        next_s.serial_sr = {s.serial_sr[6:0], overhead_insert_serial_in};
        // Transmit byte shaping
        next_s.tx_out = tx_byte_in;
        if (s.tx_diag[`SOH_TXD_ZERO_STREAM])
        begin
            next_s.tx_out = 8'h00;
        end
        else
        begin
            case (kind)
                SOH_KIND_PAYLOAD:
                begin
                    if (s.ais_on)
                    begin
                        next_s.tx_out = `SOH_ALL_ONES;
                    end
                end
                SOH_KIND_A1:
                begin
                    if (s.tx_diag[`SOH_TXD_FRAMING_INJECT])
                    begin
                        next_s.tx_out = tx_byte_in ^ `SOH_A1_MSB_FLIP;
                    end
                end
                SOH_KIND_B1:
                begin
                    if (s.tx_diag[`SOH_TXD_PARITY_INVERT])
                    begin
                        next_s.tx_out = ~tx_byte_in;
                    end
                end
                SOH_KIND_Z1_FIRST:
                begin
                    next_s.tx_out = overhead_insert_enable_pin ? s.serial_sr : s.tx_sync;
                end
                default:
                begin
                    next_s.tx_out = tx_byte_in;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            s <= '{tx_sync: `SOH_RST_TX_SYNC, rx_ctrl: `SOH_RST_RX_CTRL, tx_ctrl: `SOH_RST_TX_CTRL,
                   tx_diag: `SOH_RST_TX_DIAG, flags: 4'h0, prev_alarm: 3'h0, acc: 16'h0000,
                   count: 16'h0000, rdata: 8'h00, ais_on: 1'b0, reframe: SOH_RF_IDLE,
                   serial_sr: 8'h00, tx_out: 8'h00};
        end
        else
        begin
            s <= next_s;
        end
    end

    // Outputs
    assign rd_data = s.rdata;
    assign reduced_frame_search = s.rx_ctrl[`SOH_RXC_REDUCED_SEARCH];
    assign descrambler_off = s.rx_ctrl[`SOH_RXC_DESCR_OFF];
    assign force_reframe = (s.reframe == SOH_RF_FIRE);
    assign scrambler_off = s.tx_ctrl[`SOH_TXC_SCRAMBLER_OFF];
    assign line_alarm_active = s.ais_on;
    assign tx_byte_out = s.tx_out;
    assign irq = |(s.flags & enables);

    // Checks
    default clocking soh_cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    sequence soh_reframe_req_s;
        wr_rx_ctrl && wr_data[`SOH_RXC_FORCE_REFRAME] && (s.reframe == SOH_RF_IDLE);
    endsequence

    sequence soh_reframe_pulse_s;
        force_reframe ##1 !force_reframe;
    endsequence

    flag_set_wins_a: assert property ((misframe_state != s.prev_alarm[0]) |=> s.flags[0])
        else $error("misframe change did not set its flag");

    flag_read_clear_a: assert property ((rd_status && !(b1_check && (b1_err_bits != 4'h0)))
        |=> !s.flags[3])
        else $error("parity flag survived status read");

    parity_irq_a: assert property ((b1_check && (b1_err_bits != 4'h0) && s.rx_ctrl[`SOH_RXC_PARITY_EN]
        && !wr_rx_ctrl) |=> irq)
        else $error("parity error did not raise interrupt");

    alarm_irq_a: assert property ((s.flags[2:0] == 3'h0 && !events[3] && s.flags[3] == 1'b0
        && !rd_status && (signal_loss_state != s.prev_alarm[2]) && s.rx_ctrl[`SOH_RXC_LOS_EN]
        && !wr_rx_ctrl) |=> irq ##1 (irq || $past(rd_status)))
        else $error("signal loss change did not raise interrupt");

    status_live_a: assert property (rd_status |=> rd_data[2:0] == $past(alarm_now))
        else $error("status read did not show live alarms");

    count_latch_a: assert property (poll |=> (s.count == $past(s.acc)) && (s.acc == $past(inc)))
        else $error("count poll did not transfer and restart");

    count_mode_a: assert property ((b1_check && !poll && s.rx_ctrl[`SOH_RXC_PER_FRAME] && s.acc < 16'hFFF0)
        |=> s.acc == $past(s.acc) + 16'h0001 - {15'h0000, $past(b1_err_bits) == 4'h0})
        else $error("per-frame counting added wrong amount");

    reframe_seq_a: assert property (soh_reframe_req_s ##1 (!rx_frame_start) |=> !force_reframe)
        else $error("reframe fired before frame boundary");

    reframe_fire_a: assert property ((s.reframe == SOH_RF_PENDING) && rx_frame_start
        |=> soh_reframe_pulse_s)
        else $error("reframe did not fire for one cycle at boundary");

    ais_boundary_a: assert property ($changed(s.ais_on) |-> $past(tx_frame_start))
        else $error("line AIS changed off a frame boundary");

    ais_fill_a: assert property ((s.ais_on && !s.tx_diag[`SOH_TXD_ZERO_STREAM] && kind == SOH_KIND_PAYLOAD)
        |=> tx_byte_out == 8'hFF)
        else $error("AIS payload byte not all ones");

    a1_inject_a: assert property ((s.tx_diag == 8'h01 && kind == SOH_KIND_A1 && tx_byte_in == 8'hF6)
        |=> tx_byte_out == 8'h76)
        else $error("framing inject did not flip A1 msb");

    b1_invert_a: assert property ((s.tx_diag == 8'h02 && kind == SOH_KIND_B1)
        |=> tx_byte_out == ~$past(tx_byte_in))
        else $error("B1 byte not inverted");

    zero_force_a: assert property (s.tx_diag[`SOH_TXD_ZERO_STREAM] |=> tx_byte_out == 8'h00)
        else $error("zero stream not forced");

    z1_insert_a: assert property ((kind == SOH_KIND_Z1_FIRST && s.tx_diag == 8'h00)
        |=> tx_byte_out == ($past(overhead_insert_enable_pin) ? $past(s.serial_sr) : $past(s.tx_sync)))
        else $error("Z1 slot carried wrong byte");

    // Read data stands only in the cycle after a read
    rdata_idle_a: assert property (!rd_strobe |=> rd_data == 8'h00)
        else $error("read data not idle after a cycle without read");

    irq_clear_a: assert property ((rd_status && events == 4'h0) |=> !irq)
        else $error("interrupt stayed after status read");

    count_bits_a: assert property ((b1_check && !poll && !s.rx_ctrl[`SOH_RXC_PER_FRAME]
        && s.acc < 16'hFFF0) |=> s.acc == $past(s.acc) + {12'h000, $past(b1_err_bits)})
        else $error("per-bit counting added wrong amount");

    ais_request_a: assert property (tx_frame_start
        |=> s.ais_on == $past(s.tx_ctrl[`SOH_TXC_LINE_AIS] | ext_line_alarm_pin))
        else $error("line AIS did not follow its request at frame boundary");

    ctrl_levels_a: assert property (wr_rx_ctrl
        |=> (reduced_frame_search == $past(wr_data[`SOH_RXC_REDUCED_SEARCH]))
        && (descrambler_off == $past(wr_data[`SOH_RXC_DESCR_OFF])))
        else $error("receive control levels did not follow write");

endmodule : soh_section_regs

/* File: soh_line_model.sv */
// Behavioural model of the line side: receive framer status and transmit byte source
module soh_line_model
(
    // Clock
    input wire logic core_clk,
    // Receive framer status
    output logic rx_frame_start,
    output logic misframe_state,
    output logic frame_loss_state,
    output logic signal_loss_state,
    output logic b1_check,
    output logic [3:0] b1_err_bits,
    // Transmit byte source and pins
    output logic tx_frame_start,
    output logic [2:0] tx_byte_kind,
    output logic [7:0] tx_byte_in,
    output logic ext_line_alarm_pin,
    output logic overhead_insert_enable_pin,
    output logic overhead_insert_serial_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quiet line at time zero
    initial
    begin
        {rx_frame_start, tx_frame_start, b1_check, b1_err_bits, tx_byte_kind, tx_byte_in} = '0;
        {misframe_state, frame_loss_state, signal_loss_state} = '0;
        {ext_line_alarm_pin, overhead_insert_enable_pin, overhead_insert_serial_in} = '0;
    end

    // One frame boundary pulse on either side
    task automatic frame(input logic rx, input logic tx);
        @(posedge core_clk);
        rx_frame_start <= rx;
        tx_frame_start <= tx;
        @(posedge core_clk);
        rx_frame_start <= 1'b0;
        tx_frame_start <= 1'b0;
    endtask : frame

    // One B1 comparison; the count is garbled once unqualified
    task automatic b1(input logic [3:0] n);
        @(posedge core_clk);
        b1_check <= 1'b1;
        b1_err_bits <= n;
        @(posedge core_clk);
        b1_check <= 1'b0;
        b1_err_bits <= ~n;
    endtask : b1

    // Present one transmit byte
    task automatic tx(input logic [2:0] k, input logic [7:0] d);
        @(posedge core_clk);
        tx_byte_kind <= k;
        tx_byte_in <= d;
    endtask : tx

    // Live alarm levels: loss of signal, loss of frame, misframe
    task automatic alarms(input logic [2:0] a);
        @(posedge core_clk);
        {signal_loss_state, frame_loss_state, misframe_state} <= a;
    endtask : alarms

    // External alarm and serial overhead pins
    task automatic pins(input logic ais, input logic en, input logic ser);
        @(posedge core_clk);
        ext_line_alarm_pin <= ais;
        overhead_insert_enable_pin <= en;
        overhead_insert_serial_in <= ser;
    endtask : pins
endmodule : soh_line_model

/* File: soh_section_regs_tb_top.sv */
// Self-checking bench for the section overhead register bank
module soh_section_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk;
    logic reset;
    logic [7:0] addr;
    logic [7:0] wr_data;
    logic wr_strobe;
    logic rd_strobe;
    logic meter_load;
    wire rx_frame_start, misframe_state, frame_loss_state, signal_loss_state, b1_check;
    wire [3:0] b1_err_bits;
    wire tx_frame_start, ext_line_alarm_pin, overhead_insert_enable_pin, overhead_insert_serial_in;
    wire [2:0] tx_byte_kind;
    wire [7:0] tx_byte_in;
    logic [7:0] rd_data, tx_byte_out;
    logic reduced_frame_search, descrambler_off, force_reframe, scrambler_off, line_alarm_active, irq;
    int n_mismatch = 0;
    int comparisons = 0;
    logic [7:0] rst_addr [8] = '{8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h20};

    // Idle bus and reset asserted at time zero
    initial
    begin
        core_clk = 1'b0;
        reset = 1'b1;
        {addr, wr_data, wr_strobe, rd_strobe, meter_load} = '0;
    end

    // Clock at 20 MHz
    always #25 core_clk = ~core_clk;

    soh_section_regs u_soh_section_regs (.core_clk, .reset, .addr, .wr_data, .wr_strobe, .rd_strobe,
        .rd_data, .meter_load, .rx_frame_start, .misframe_state, .frame_loss_state, .signal_loss_state,
        .b1_check, .b1_err_bits, .reduced_frame_search, .descrambler_off, .force_reframe, .tx_frame_start,
        .tx_byte_kind, .tx_byte_in, .ext_line_alarm_pin, .overhead_insert_enable_pin,
        .overhead_insert_serial_in, .tx_byte_out, .scrambler_off, .line_alarm_active, .irq);

    soh_line_model u_soh_line_model (.core_clk, .rx_frame_start, .misframe_state, .frame_loss_state,
        .signal_loss_state, .b1_check, .b1_err_bits, .tx_frame_start, .tx_byte_kind, .tx_byte_in,
        .ext_line_alarm_pin, .overhead_insert_enable_pin, .overhead_insert_serial_in);

    // Compare and report
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic flag(input string name, input logic seen, input logic exp);
        check(name, {7'h00, seen}, {7'h00, exp});
    endtask : flag

    // Register bus cycles
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wr_data <= d;
        wr_strobe <= 1'b1;
        @(posedge core_clk);
        wr_strobe <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge core_clk);
        rd_strobe <= 1'b0;
        #1;
        check($sformatf("register %h", a), rd_data, exp);
    endtask : rd

    // Let one more edge land
    task automatic settle();
        @(posedge core_clk);
        #1;
    endtask : settle

    // Shaped transmit byte one cycle after it is presented
    task automatic txc(input logic [2:0] k, input logic [7:0] d, input logic [7:0] exp);
        u_soh_line_model.tx(k, d);
        settle();
        check("tx_byte_out", tx_byte_out, exp);
    endtask : txc

    // Verdict
    task automatic complete_run();
        if (n_mismatch == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    // Watchdog
    initial
    begin
        repeat (5000) @(posedge core_clk);
        n_mismatch++;
        complete_run();
    end

    // Main sequence
    initial
    begin
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        foreach (rst_addr[i]) rd(rst_addr[i], 8'h00);
        wr(8'h0F, 8'h5A);
        wr(8'h20, 8'hFF);
        rd(8'h0F, 8'h5A);
        rd(8'h20, 8'h00);
        // Receive controls and frame-aligned reframe
        wr(8'h10, 8'h70);
        rd(8'h10, 8'h50);
        flag("reduced_frame_search", reduced_frame_search, 1'b1);
        flag("descrambler_off", descrambler_off, 1'b1);
        flag("force_reframe", force_reframe, 1'b0);
        u_soh_line_model.frame(1'b1, 1'b0);
        #1;
        flag("force_reframe", force_reframe, 1'b1);
        settle();
        flag("force_reframe", force_reframe, 1'b0);
        wr(8'h10, 8'h01);
        flag("reduced_frame_search", reduced_frame_search, 1'b0);
        flag("descrambler_off", descrambler_off, 1'b0);
        // Alarm states, flags and masking
        u_soh_line_model.alarms(3'b001);
        repeat (2) settle();
        flag("irq", irq, 1'b1);
        rd(8'h11, 8'h09);
        settle();
        flag("irq", irq, 1'b0);
        rd(8'h11, 8'h01);
        u_soh_line_model.alarms(3'b011);
        repeat (2) settle();
        flag("irq", irq, 1'b0);
        rd(8'h11, 8'h13);
        wr(8'h10, 8'h04);
        u_soh_line_model.alarms(3'b111);
        repeat (2) settle();
        flag("irq", irq, 1'b1);
        rd(8'h11, 8'h27);
        u_soh_line_model.alarms(3'b000);
        rd(8'h11, 8'h38);
        // Parity counting, polling and coincident events
        wr(8'h10, 8'h08);
        u_soh_line_model.b1(4'h3);
        u_soh_line_model.b1(4'h5);
        repeat (2) settle();
        flag("irq", irq, 1'b1);
        fork
            wr(8'h12, 8'h00);
            u_soh_line_model.b1(4'h2);
        join
        rd(8'h12, 8'h08);
        rd(8'h13, 8'h00);
        wr(8'h10, 8'h88);
        u_soh_line_model.b1(4'h7);
        @(posedge core_clk);
        meter_load <= 1'b1;
        @(posedge core_clk);
        meter_load <= 1'b0;
        rd(8'h12, 8'h03);
        rd(8'h11, 8'h40);
        wr(8'h10, 8'h00);
        repeat (33) u_soh_line_model.b1(4'h8);
        wr(8'h13, 8'h00);
        rd(8'h12, 8'h08);
        rd(8'h13, 8'h01);
        // Z1 insertion from register and serial pins
        txc(3'h4, 8'h33, 8'h5A);
        // Serial byte sent first bit first, one bit a cycle
        for (int i = 7; i >= 0; i--) u_soh_line_model.pins(1'b0, 1'b1, 1'(8'hA5 >> i));
        txc(3'h4, 8'h33, 8'hA5);
        u_soh_line_model.pins(1'b0, 1'b1, 1'b0);
        repeat (8) @(posedge core_clk);
        txc(3'h4, 8'h33, 8'h00);
        u_soh_line_model.pins(1'b0, 1'b0, 1'b1);
        // Diagnostic injections
        wr(8'h15, 8'h01);
        txc(3'h2, 8'hF6, 8'h76);
        wr(8'h15, 8'h02);
        txc(3'h3, 8'h3C, 8'hC3);
        txc(3'h2, 8'hF6, 8'hF6);
        wr(8'h15, 8'h04);
        txc(3'h0, 8'h5A, 8'h00);
        wr(8'h15, 8'h00);
        // Line AIS aligned to frame boundaries
        wr(8'h14, 8'h41);
        flag("scrambler_off", scrambler_off, 1'b1);
        txc(3'h0, 8'h12, 8'h12);
        flag("line_alarm_active", line_alarm_active, 1'b0);
        u_soh_line_model.frame(1'b0, 1'b1);
        txc(3'h0, 8'h12, 8'hFF);
        txc(3'h1, 8'h12, 8'h12);
        flag("line_alarm_active", line_alarm_active, 1'b1);
        wr(8'h14, 8'h00);
        flag("scrambler_off", scrambler_off, 1'b0);
        txc(3'h0, 8'h12, 8'hFF);
        u_soh_line_model.frame(1'b0, 1'b1);
        txc(3'h0, 8'h12, 8'h12);
        u_soh_line_model.pins(1'b1, 1'b0, 1'b0);
        u_soh_line_model.frame(1'b0, 1'b1);
        txc(3'h0, 8'h12, 8'hFF);
        complete_run();
    end
endmodule : soh_section_regs_tb_top
